// ### design/sahm_addr_match.v
/*
  Slave address recognition and automatic acknowledge of a serial
  management bus port, with the acknowledge quirks of the modelled silicon.
  Assumes: SCL and SDA arrive unsynchronised from open-drain pins; the
  special-function-register bus, hold_extension, ack-select writes, flag
  clears and arbitration-lost come from logic on core_clk_in.

  // Function
  // (R1) Mask one bits compare address with own
  // (R2) Mask zero bits are don't-care
  // (R3) Hardware ack off: software acks everything
  // (R4) Hardware ack on: auto match and ack
  // (R5) Extension off: interrupt every address seen
  // (R6) Extension on: interrupt only on match
  // (R7) Extension on clears start flag on address
  // (R8) Unaddressed slave acks when ack-select set
  // (R9) Any bus ack sets unaddressed ack-select
  // (R10) Hold SCL low until interrupt flag cleared
  // (R11) Unaddressed data writes never reach bus
  // (R12) Matched address still acked without start
  // (R13) Lost-arbitration master acks foreign transfers
  // (R14) Software checks address, clears flag fast
  // (R15) Software tracks in-transfer bit itself
  // (R16) Software toggles extension for repeated start
  // (R17) Software timer clears ack-select under 7 bits
  // (R18) Software stops timer on match, restarts after
  // (R19) General call accepted when enabled
  // (R20) Receive interrupt before ack off, after on
  // (R21) Software preloads ack value before byte
  // (R22) Software disables hardware ack as multi-master
  // (R23) Compare only first byte's seven address bits
*/
`timescale 1ns/10ps
`include "sahm_map.vh"
`default_nettype none

module sahm_addr_match (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire [7:0] sfr_addr_in,
  input wire sfr_wr_in,
  input wire sfr_rd_in,
  input wire [7:0] sfr_wdata_in,
  output reg [7:0] sfr_rdata_out,
  input wire hold_extension_in,
  input wire arb_lost_in,
  input wire ack_sel_wr_in,
  input wire ack_sel_wdata_in,
  input wire serial_int_clr_in,
  input wire start_flag_clr_in,
  input wire stop_flag_clr_in,
  input wire scl_in,
  input wire sda_in,
  output reg scl_out,
  output reg scl_oe_n_out,
  output reg sda_out,
  output reg sda_oe_n_out,
  output reg ack_sel_out,
  output reg serial_int_flag_out,
  output reg start_flag_out,
  output reg stop_flag_out,
  output reg addressed_out
);
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_ADDR = 2'h1;
  localparam [1:0] ST_DATA = 2'h2;
  // Masked compare of a received address against own address and mask
  function addr_hit;
    input [6:0] rx;
    input [6:0] own;
    input [6:0] mask;
    input gc_en;
    begin
      addr_hit = (((rx ^ own) & mask) == 7'h00) || (gc_en && (rx == `SAHM_GEN_CALL));
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bus condition detection
  reg scl_meta_ff;
  reg scl_sync_ff;
  reg scl_prev_ff;
  reg sda_meta_ff;
  reg sda_sync_ff;
  reg sda_prev_ff;
  always @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      scl_meta_ff <= 1'b1;
      scl_sync_ff <= 1'b1;
      scl_prev_ff <= 1'b1;
      sda_meta_ff <= 1'b1;
      sda_sync_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end
    else
    begin
      scl_meta_ff <= scl_in;
      scl_sync_ff <= scl_meta_ff;
      scl_prev_ff <= scl_sync_ff;
      sda_meta_ff <= sda_in;
      sda_sync_ff <= sda_meta_ff;
      sda_prev_ff <= sda_sync_ff;
    end
  end

  wire scl_rise = scl_sync_ff && !scl_prev_ff;
  wire scl_fall = !scl_sync_ff && scl_prev_ff;
  wire bus_start = scl_sync_ff && scl_prev_ff && !sda_sync_ff && sda_prev_ff;
  wire bus_stop = scl_sync_ff && scl_prev_ff && sda_sync_ff && !sda_prev_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Registers on the special-function-register bus
  reg [7:0] own_addr_ff;
  reg [7:0] mask_hwack_ff;
  reg [7:0] data_ff;
  reg [7:0] shift_ff;
  reg [3:0] bit_cnt_ff;
  reg [1:0] state_ff;
  reg ack_phase_ff;
  reg rw_ff;
  wire [6:0] own_slave_address = own_addr_ff[`SAHM_ADDR_MSB:`SAHM_ADDR_LSB];
  wire general_call_enable = own_addr_ff[`SAHM_GC_BIT];
  wire [6:0] slave_address_mask = mask_hwack_ff[`SAHM_ADDR_MSB:`SAHM_ADDR_LSB];
  wire hw_ack_enable = mask_hwack_ff[`SAHM_HWACK_BIT];
  wire byte_done = scl_fall && (bit_cnt_ff == `SAHM_CNT_BYTE);
  wire ack_done = scl_fall && (bit_cnt_ff == `SAHM_CNT_ACK);
  wire ack_sample = scl_rise && (bit_cnt_ff == `SAHM_CNT_BYTE);
  wire in_addr = (state_ff == ST_ADDR);
  wire in_data = (state_ff == ST_DATA);
  // Only the first byte after a start is compared, direction bit excluded
  wire addr_match = in_addr && addr_hit(shift_ff[`SAHM_ADDR_MSB:`SAHM_ADDR_LSB], own_slave_address,
                                       slave_address_mask, general_call_enable); // [R1] [R2] [R19] [R23]
  always @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      own_addr_ff <= `SAHM_RST_OWN_ADDR;
      mask_hwack_ff <= `SAHM_RST_MASK_HWACK;
      data_ff <= `SAHM_RST_DATA;
      sfr_rdata_out <= `SAHM_RST_RDATA;
    end
    else
    begin
      if (sfr_wr_in && (sfr_addr_in == `SAHM_OFS_OWN_ADDR))
        own_addr_ff <= sfr_wdata_in;
      if (sfr_wr_in && (sfr_addr_in == `SAHM_OFS_MASK_HWACK))
        mask_hwack_ff <= sfr_wdata_in;
      // Received byte wins; a CPU write only stores, it never drives SDA
      if (byte_done)
        data_ff <= shift_ff;
      else if (sfr_wr_in && (sfr_addr_in == `SAHM_OFS_DATA))
        data_ff <= sfr_wdata_in; // [R11]
      if (sfr_rd_in)
      begin
        case (sfr_addr_in)
          `SAHM_OFS_OWN_ADDR: sfr_rdata_out <= own_addr_ff;
          `SAHM_OFS_MASK_HWACK: sfr_rdata_out <= mask_hwack_ff;
          `SAHM_OFS_DATA: sfr_rdata_out <= data_ff;
          default: sfr_rdata_out <= `SAHM_RST_RDATA;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame tracking
  always @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= `SAHM_CNT_ZERO;
      shift_ff <= 8'h00;
      ack_phase_ff <= 1'b0;
      rw_ff <= 1'b0;
    end
    else if (bus_start)
    begin
      state_ff <= ST_ADDR;
      bit_cnt_ff <= `SAHM_CNT_ZERO;
      ack_phase_ff <= 1'b0;
    end
    else if (bus_stop)
    begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= `SAHM_CNT_ZERO;
      ack_phase_ff <= 1'b0;
    end
    else if (state_ff != ST_IDLE)
    begin
      if (scl_rise && (bit_cnt_ff < `SAHM_CNT_ACK))
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
      if (scl_rise && (bit_cnt_ff < `SAHM_CNT_BYTE))
        shift_ff <= {shift_ff[6:0], sda_sync_ff};
      if (byte_done)
      begin
        ack_phase_ff <= 1'b1;
        if (in_addr)
          rw_ff <= shift_ff[`SAHM_RW_BIT];
      end
      if (ack_done)
      begin
        ack_phase_ff <= 1'b0;
        bit_cnt_ff <= `SAHM_CNT_ZERO;
        state_ff <= ST_DATA;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge drive
  reg own_ack;
  reg quirk_ack;
  always @*
  begin
    own_ack = 1'b0;
    quirk_ack = 1'b0;
    if (ack_phase_ff)
    begin
      if (!hw_ack_enable)
        own_ack = ack_sel_out && (in_addr || (addressed_out && !rw_ff)); // [R3]
      else if (in_addr)
        own_ack = addr_match; // [R4] [R12]
      else
        own_ack = addressed_out && !rw_ff && ack_sel_out; // [R4]
      if (hw_ack_enable && !addressed_out && !own_ack)
        quirk_ack = ack_sel_out || arb_lost_in; // [R8] [R13]
    end
  end
  always @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sda_out <= 1'b0;
      sda_oe_n_out <= 1'b1;
      scl_out <= 1'b0;
      scl_oe_n_out <= 1'b1;
    end
    else
    begin
      sda_oe_n_out <= !(own_ack || quirk_ack);
      // Stretch only once SCL is already low, never pull a high clock down
      scl_oe_n_out <= !(serial_int_flag_out && (!scl_sync_ff || !scl_oe_n_out)); // [R10]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags, ack select and addressed state
  wire addr_int = ack_done && in_addr && (hw_ack_enable ? (addr_match || !hold_extension_in)
                                                       : 1'b0); // [R5] [R6]
  wire addr_int_early = byte_done && in_addr && !hw_ack_enable; // [R3]
  wire data_int_early = byte_done && in_data && addressed_out && !hw_ack_enable && !rw_ff; // [R20]
  wire data_int_late = ack_done && in_data && addressed_out && (hw_ack_enable || rw_ff); // [R20]
  wire int_set = addr_int || addr_int_early || data_int_early || data_int_late;
  wire start_set = in_addr && (hw_ack_enable ? ack_done && addr_match && !hold_extension_in
                                             : byte_done);
  wire start_kill = ack_done && in_addr && hw_ack_enable && hold_extension_in; // [R7]
  always @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      serial_int_flag_out <= 1'b0;
      start_flag_out <= 1'b0;
      stop_flag_out <= 1'b0;
      ack_sel_out <= 1'b0;
      addressed_out <= 1'b0;
    end
    else
    begin
      if (int_set)
        serial_int_flag_out <= 1'b1;
      else if (serial_int_clr_in)
        serial_int_flag_out <= 1'b0;
      if (start_set)
        start_flag_out <= 1'b1;
      else if (start_kill || start_flag_clr_in)
        start_flag_out <= 1'b0;
      if (bus_stop && addressed_out)
        stop_flag_out <= 1'b1;
      else if (stop_flag_clr_in)
        stop_flag_out <= 1'b0;
      // Any ack seen while unaddressed with hardware ack on, this port's own address ack included, arms ack select
      if (ack_sample && !sda_sync_ff && !addressed_out && hw_ack_enable)
        ack_sel_out <= 1'b1; // [R9]
      else if (ack_sel_wr_in)
        ack_sel_out <= ack_sel_wdata_in;
      if (bus_start || bus_stop)
        addressed_out <= 1'b0;
      else if (ack_done && in_addr)
        addressed_out <= !sda_oe_n_out && !quirk_ack; // [R12]
    end
  end

endmodule
`default_nettype wire

// ### design/sahm_map.vh
/*
  Register offsets, field positions, reset values and frame counts of the
  slave address match and hardware acknowledge block.
  Assumes an 8-bit special-function-register bus with byte addresses.
*/
`ifndef SAHM_MAP_VH
`define SAHM_MAP_VH

// Register offsets on the special-function-register bus
`define SAHM_OFS_OWN_ADDR   8'hf4
`define SAHM_OFS_MASK_HWACK 8'hf5
`define SAHM_OFS_DATA       8'hc2

// Fields
`define SAHM_GC_BIT    0
`define SAHM_HWACK_BIT 0
`define SAHM_ADDR_MSB  7
`define SAHM_ADDR_LSB  1
`define SAHM_RW_BIT    0

// Reset values
`define SAHM_RST_OWN_ADDR   8'h00
`define SAHM_RST_MASK_HWACK 8'hfe
`define SAHM_RST_DATA       8'h00
`define SAHM_RST_RDATA      8'h00

// Frame counts: rising SCL edges after which the byte and the ack bit end
`define SAHM_CNT_BYTE 4'h8
`define SAHM_CNT_ACK  4'h9
`define SAHM_CNT_ZERO 4'h0

// General call address
`define SAHM_GEN_CALL 7'h00

`endif

// ### testbench/sahm_addr_match_props.sv
/* Port checker for the address match block.
   Assumes a bind to sahm_addr_match. */
`timescale 1ns/10ps
`default_nettype none
module sahm_chk (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic hold_extension_in,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe_n_out,
  input wire logic sda_out,
  input wire logic sda_oe_n_out,
  input wire logic ack_sel_out,
  input wire logic serial_int_flag_out,
  input wire logic start_flag_out,
  input wire logic stop_flag_out,
  input wire logic addressed_out
);
  logic hw_ff;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Mirror of the hardware ack enable
  always_ff @(posedge core_clk_in or negedge rst_n_in)
    if (!rst_n_in)
      hw_ff <= 1'b0;
    else if (sfr_wr_in && sfr_addr_in == 8'hf5)
      hw_ff <= sfr_wdata_in[0];
  a_pin_low:
    assert property (!scl_out && !sda_out) else $error("pin data high");
  a_stretch_int:
    assert property (!scl_oe_n_out |-> serial_int_flag_out || $past(serial_int_flag_out)) else $error("stray hold");
  a_stretch_low:
    assert property ($fell(scl_oe_n_out) |-> !$past(scl_in)) else $error("hold on high");
  a_int_match:
    assert property (hw_ff && hold_extension_in && $rose(serial_int_flag_out) |-> addressed_out || stop_flag_out)
      else $error("int no match");
  a_start_kill:
    assert property (hw_ff && hold_extension_in && $rose(serial_int_flag_out) |-> !start_flag_out)
      else $error("start kept");
  a_int_post_ack:
    // The ack drive lets go one cycle after the flag rises
    assert property (hw_ff && $rose(serial_int_flag_out) |=> sda_oe_n_out) else $error("int in ack");
  a_no_hw_ack:
    assert property (!hw_ff && !$past(hw_ff) && !ack_sel_out && !$past(ack_sel_out) |-> sda_oe_n_out)
      else $error("ack unasked");
  a_ack_len:
    assert property ($fell(sda_oe_n_out) |-> !sda_oe_n_out [*4]) else $error("short ack");
endmodule
bind sahm_addr_match sahm_chk u_sahm_chk (.core_clk_in, .rst_n_in, .sfr_addr_in, .sfr_wr_in, .sfr_wdata_in,
  .hold_extension_in, .scl_in, .scl_out, .scl_oe_n_out, .sda_out, .sda_oe_n_out, .ack_sel_out,
  .serial_int_flag_out, .start_flag_out, .stop_flag_out, .addressed_out);
`default_nettype wire

// ### testbench/sahm_bus_master.sv
/* Bus master model: start, byte plus ack bit, stop; 400 ns bits.
   Assumes the bench resolves pulled-up wires. */
`timescale 1ns/10ps
`default_nettype none
module sahm_bus_master (
  input wire logic scl_in,
  input wire logic sda_in,
  output var logic scl_out = 1'b1,
  output var logic sda_out = 1'b1
);
  int stalls = 0;
  // Release SCL and wait out a stretch; one that outlasts 10 us is a stall
  task automatic rise();
    scl_out = 1'b1;
    for (int i = 0; i < 200 && !scl_in; i++)
      #50;
    if (!scl_in)
      stalls++;
  endtask
  task automatic start();
    #207 sda_out = 1'b0;
    #200 scl_out = 1'b0;
  endtask
  // MSB first, then the released ack bit lands in k
  task automatic put(input logic [7:0] d, output logic k);
    logic [8:0] s;
    s = {d, 1'b1};
    repeat (9)
    begin
      #100 sda_out = s[8];
      s = s << 1;
      #100 rise();
      #100 k = sda_in;
      #100 scl_out = 1'b0;
    end
  endtask
  task automatic stop();
    #100 sda_out = 1'b0;
    #100 rise();
    #200 sda_out = 1'b1;
  endtask
endmodule
`default_nettype wire

// ### testbench/sahm_addr_match_test.sv
/* Bench for the address match block with a bus master model.
   Assumes 20 MHz clock and 400 ns bus bits. */
`timescale 1ns/10ps
`default_nettype none
module sahm_addr_match_test;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, hold = 1'b1, aswr = 1'b0, asd = 1'b0, clr = 1'b0, k;
  logic arb = 1'b0;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata;
  logic scl_o, scl_oe_n, sda_o, sda_oe_n, ack_sel, sflag, stflag, spflag, adr, mscl, msda;
  wire logic scl_w = mscl & (scl_oe_n | scl_o);
  wire logic sda_w = msda & (sda_oe_n | sda_o);
  int failures = 0;
  int samples_checked = 0;
  sahm_addr_match u_sahm_addr_match (.core_clk_in(clk), .rst_n_in(rst_n), .sfr_addr_in(addr), .sfr_wr_in(wr),
    .sfr_rd_in(rd), .sfr_wdata_in(wd), .sfr_rdata_out(rdata), .hold_extension_in(hold), .arb_lost_in(arb),
    .ack_sel_wr_in(aswr), .ack_sel_wdata_in(asd), .serial_int_clr_in(clr), .start_flag_clr_in(1'b0),
    .stop_flag_clr_in(clr), .scl_in(scl_w), .sda_in(sda_w), .scl_out(scl_o), .scl_oe_n_out(scl_oe_n),
    .sda_out(sda_o), .sda_oe_n_out(sda_oe_n), .ack_sel_out(ack_sel), .serial_int_flag_out(sflag),
    .start_flag_out(stflag), .stop_flag_out(spflag), .addressed_out(adr));
  sahm_bus_master m (.scl_in(scl_w), .sda_in(sda_w), .scl_out(mscl), .sda_out(msda));
  initial
    forever #25 clk = ~clk;
  task automatic end_sim();
    failures += m.stalls;
    if (failures == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] s, e);
    samples_checked++;
    if (s !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic chkb(input string n, input logic s, e);
    chk(n, {7'h0, s}, {7'h0, e});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wreg(input logic [7:0] a, d);
    cyc(1);
    addr = a;
    wd = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, e);
    cyc(1);
    addr = a;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    chk("rdata", rdata, e);
  endtask
  task automatic ack(input logic v);
    cyc(1);
    asd = v;
    aswr = 1'b1;
    cyc(1);
    aswr = 1'b0;
  endtask
  task automatic drop();
    cyc(1);
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] a, input logic ea, ei, dat);
    m.start();
    m.put(a, k);
    cyc(6);
    chkb("ack", ~k, ea);
    chkb("int", sflag, ei);
    chkb("addressed", adr, ea & ei);
    chkb("hold", scl_oe_n, ~ei);
    drop();
    if (dat)
    begin
      chkb("start", stflag, 1'b0);
      m.put(8'ha5, k);
      cyc(6);
      chkb("data_ack", ~k, 1'b1);
      chkb("data_int", sflag, 1'b1);
      drop();
      rreg(8'hc2, 8'ha5);
    end
    m.stop();
    cyc(6);
    chkb("stop", spflag, ea & ei);
    drop();
  endtask
  task automatic hw_off();
    int n = 0;
    wreg(8'hf5, 8'hfc);
    ack(1'b0);
    m.start();
    fork
      m.put(8'h68, k);
      begin
        while (sflag !== 1'b1 && n < 400)
        begin
          cyc(1);
          n++;
        end
        chkb("early_int", sflag, 1'b1);
        if (n == 400)
          end_sim();
        chkb("no_ack_yet", sda_oe_n, 1'b1);
        ack(1'b1);
        drop();
      end
    join
    chkb("sw_ack", ~k, 1'b1);
    m.stop();
    cyc(6);
    drop();
  endtask
  initial
  begin
    cyc(16);
    rst_n = 1'b1;
    rreg(8'hf5, 8'hfe);
    rreg(8'hf4, 8'h00);
    rreg(8'h10, 8'h00);
    wreg(8'hf4, 8'h69);
    wreg(8'hf5, 8'hfd);
    rreg(8'hf5, 8'hfd);
    ack(1'b1);
    hold = 1'b0;
    xfer(8'h68, 1'b1, 1'b1, 1'b0);
    chkb("start_seen", stflag, 1'b1);
    hold = 1'b1;
    xfer(8'h6a, 1'b1, 1'b1, 1'b1);
    ack(1'b0);
    xfer(8'h6c, 1'b0, 1'b0, 1'b0);
    xfer(8'h00, 1'b1, 1'b1, 1'b0);
    chkb("ack_sel", ack_sel, 1'b1);
    ack(1'b0);
    hold = 1'b0;
    xfer(8'h6c, 1'b0, 1'b1, 1'b0);
    hold = 1'b1;
    ack(1'b1);
    xfer(8'h6c, 1'b1, 1'b0, 1'b0);
    ack(1'b0);
    arb = 1'b1;
    xfer(8'h6c, 1'b1, 1'b0, 1'b0);
    arb = 1'b0;
    hw_off();
    end_sim();
  end
endmodule
`default_nettype wire
